//--- rtl/gas_register_defines.vh
/*
 Addresses, field positions, limits and timing counts of the register bank.
 Assumes inclusion by bare name.
*/
`ifndef GAS_REGISTER_DEFINES_VH
`define GAS_REGISTER_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_SETTINGS 7'h01
`define ADDR_DISPLAY 7'h02
`define ADDR_UNITS 7'h03
`define ADDR_ALARM_SETUP 7'h1B
`define ADDR_STATUS 7'h4D
`define ADDR_RTC_HOUR_MIN 7'h4E
`define ADDR_RTC_SEC_DAY 7'h4F
`define ADDR_RTC_MONTH_YEAR 7'h50
`define ADDR_SET_HOUR 7'h41
`define ADDR_SET_MIN 7'h42
`define ADDR_SET_DAY 7'h43
`define ADDR_SET_MONTH 7'h44
`define ADDR_SET_YEAR 7'h45

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define SETTINGS_MASK 16'h002D
`define UNITS_MASK 16'h383F
`define ALARM_MASK 16'h001F
`define SETTINGS_RESET 16'h0000
`define UNITS_RESET 16'h0000
`define ALARM_RESET 16'h0000
`define DISPLAY_RESET 16'h3232

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SET_FIELD_CAL 0
`define SET_EXT_COMP 2
`define SET_BG_COMP 3
`define SET_DISP_LIMIT 5
`define UNITS_CAL_TYPE 4
`define UNITS_DATE_US 5
`define ALARM_NAMUR_HIGH 4
`define ROLE_OFF 2'h0
`define ROLE_LOW 2'h1
`define ROLE_HIGH 2'h2
`define DISPLAY_MAX 8'h64
`define DISPLAY_STEP 8'h0A

// ----------------------------------------------------------------
// Scaled formats and limits
// ----------------------------------------------------------------
`define SCALED_OFFSET 17'h04E20
`define SCALED_MAX 16'h9C40
`define SIGNED_OFFSET 17'h07FFF
// Input currents in microamps
`define COMP_LOW_UA 16'h0E10
`define COMP_HIGH_UA 16'h5208
`define NAMUR_LOW_UA 16'h0C80
`define NAMUR_HIGH_UA 16'h5398
// Cell temperature in tenths of a degree Celsius, signed
`define CELL_MIN_DC (-16'sd500)
`define CELL_MAX_DC 16'sd800
// Stability band in hundredths of a degree Celsius
`define STABLE_BAND_CC 16'h000F
`define VCOMP_LOW 13'h0001
`define VCOMP_HIGH 13'h1FFF
// Stability hold: 15 minutes at 10 MHz
`define STABLE_MINUTES 15
`define CLK_HZ 34'd10000000
`define STABLE_CYCLES (`STABLE_MINUTES * 60 * `CLK_HZ)

`endif

//--- rtl/gas_register_formats.v
/*
 Gas analyser register bank, status flags, clock registers and format converters.
 Assumes same-clock bus port and measurements, two asynchronous alarm pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gas_register_defines.vh"

//Behaviour
// - Unsigned registers pass full 16 bits unscaled
// - Settings enables in bits 0,2,3,5
// - Display brightness high byte, contrast low byte
// - Units bits select temperature and pressure
// - Units bit 4 picks calibration type
// - Units bit 5 picks date order
// - Units bits 13:11 encode sensor quantity
// - One-decimal raw minus 20000, over ten; conv_tenths gives raw minus 20000, not divided
// - Two-decimal raw minus 20000, over hundred; conv_hundredths gives raw minus 20000, not divided
// - Status bits 1-3 range and alarms
// - Bit 4 compensation current out of band
// - Bit 5 sensor current out of limits
// - Bit 6 until fifteen minutes stable
// - Bit 7 cell temperature sensor fault
// - Bit 9 compensation voltage code fault
// - Bit 10 board above cell setpoint
// - Clock reads both bytes, writes low
// - Signed offset raw minus 32767
// - Alarm setup bits 1:0 first role
// - Alarm setup bits 3:2 second role
// - Alarm bit 4 picks NAMUR level
module gas_register_formats #(
    parameter [33:0] STABLE_HOLD = `STABLE_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [6:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output reg reg_rvalid,
    output reg reg_err,
    // Measurement inputs, same clock
    input wire gas_out_of_range,
    input wire [15:0] gas_reading,
    input wire [15:0] alarm1_setpoint,
    input wire [15:0] alarm2_setpoint,
    input wire [15:0] comp_current_ua,
    input wire [15:0] sensor_current_ua,
    input wire [15:0] sensor_low_ua,
    input wire [15:0] sensor_high_ua,
    input wire signed [15:0] cell_temp_dc,
    input wire signed [15:0] cell_temp_cc,
    input wire signed [15:0] cell_setpoint_cc,
    input wire [12:0] vcomp_code,
    input wire signed [15:0] board_temperature,
    input wire signed [15:0] cell_setpoint_c,
    input wire second_tick,
    // Asynchronous external alarm contacts
    input wire ext_low_alarm_pin,
    input wire ext_high_alarm_pin,
    // Register fields to the instrument
    output reg field_cal_on,
    output reg ext_comp_on,
    output reg bg_comp_on,
    output reg display_limit_on,
    output reg [7:0] brightness,
    output reg [7:0] contrast,
    output reg [1:0] temp_unit,
    output reg [1:0] press_unit,
    output reg two_gas_cal,
    output reg date_us,
    output reg [2:0] sensor_quantity,
    output reg [1:0] alarm1_role,
    output reg [1:0] alarm2_role,
    output reg [15:0] namur_fault_ua,
    output reg low_alarm,
    output reg high_alarm,
    // Format converters
    input wire [15:0] conv_raw,
    output reg signed [16:0] conv_tenths,
    output reg signed [16:0] conv_hundredths,
    output reg signed [16:0] conv_signed,
    output reg conv_in_range
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    reg [15:0] settings_enables;
    reg [15:0] display_levels;
    reg [15:0] units_select;
    reg [15:0] alarm_setup;
    reg [15:0] status_error_flags;
    reg [7:0] rtc_hour;
    reg [7:0] rtc_min;
    reg [7:0] rtc_sec;
    reg [7:0] rtc_day;
    reg [7:0] rtc_month;
    reg [7:0] rtc_year;
    reg [33:0] stable_count;
    reg not_stable;
    reg [15:0] next_rdata;
    reg next_err;
    wire ext_low_sync;
    wire ext_high_sync;

    sync_bit u_sync_low (
        .clk(clk),
        .rst(rst),
        .din(ext_low_alarm_pin),
        .dout(ext_low_sync)
    );
    sync_bit u_sync_high (
        .clk(clk),
        .rst(rst),
        .din(ext_high_alarm_pin),
        .dout(ext_high_sync)
    );

    // Display level rounded down to a ten step, capped at 100
    function [7:0] level_step;
        input [7:0] v;
        begin
            if (v > `DISPLAY_MAX) begin
                level_step = `DISPLAY_MAX;
            end else begin
                level_step = (v / `DISPLAY_STEP) * `DISPLAY_STEP;
            end
        end
    endfunction

    // Alarm decision for one role against one setpoint
    function alarm_hit;
        input [1:0] role;
        input [15:0] reading;
        input [15:0] setpoint;
        begin
            case (role)
                `ROLE_LOW: alarm_hit = reading < setpoint;
                `ROLE_HIGH: alarm_hit = reading > setpoint;
                default: alarm_hit = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            settings_enables <= `SETTINGS_RESET;
            display_levels <= `DISPLAY_RESET;
            units_select <= `UNITS_RESET;
            alarm_setup <= `ALARM_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_SETTINGS: settings_enables <= reg_wdata & `SETTINGS_MASK;
                `ADDR_DISPLAY: display_levels <= {level_step(reg_wdata[15:8]), level_step(reg_wdata[7:0])};
                `ADDR_UNITS: units_select <= reg_wdata & `UNITS_MASK;
                `ADDR_ALARM_SETUP: alarm_setup <= reg_wdata & `ALARM_MASK;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Real-time clock
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rtc_hour <= 8'h00;
            rtc_min <= 8'h00;
            rtc_sec <= 8'h00;
            rtc_day <= 8'h01;
            rtc_month <= 8'h01;
            rtc_year <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_SET_HOUR: rtc_hour <= reg_wdata[7:0];
                `ADDR_SET_MIN: rtc_min <= reg_wdata[7:0];
                `ADDR_SET_DAY: rtc_day <= reg_wdata[7:0];
                `ADDR_SET_MONTH: rtc_month <= reg_wdata[7:0];
                `ADDR_SET_YEAR: rtc_year <= reg_wdata[7:0];
                default: begin
                end
            endcase
        end else if (second_tick) begin
            // Seconds, minutes and hours roll over; calendar rollover is left to firmware
            if (rtc_sec >= 8'h3B) begin
                rtc_sec <= 8'h00;
                if (rtc_min >= 8'h3B) begin
                    rtc_min <= 8'h00;
                    rtc_hour <= (rtc_hour >= 8'h17) ? 8'h00 : rtc_hour + 8'h01;
                end else begin
                    rtc_min <= rtc_min + 8'h01;
                end
            end else begin
                rtc_sec <= rtc_sec + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Cell temperature stability timer
    // ----------------------------------------------------------------
    wire signed [16:0] cell_diff = cell_temp_cc - cell_setpoint_cc;
    wire in_band = (cell_diff <= $signed({1'b0, `STABLE_BAND_CC})) &&
                   (cell_diff >= -$signed({1'b0, `STABLE_BAND_CC}));
    always @(posedge clk) begin
        if (rst) begin
            stable_count <= 34'h000000000;
            not_stable <= 1'b1;
        end else if (!in_band) begin
            stable_count <= 34'h000000000;
            not_stable <= 1'b1;
        end else if (stable_count >= STABLE_HOLD - 34'h000000001) begin
            not_stable <= 1'b0;
        end else begin
            stable_count <= stable_count + 34'h000000001;
        end
    end

    // ----------------------------------------------------------------
    // Status flags and alarms
    // ----------------------------------------------------------------
    wire alarm1_hit = alarm_hit(alarm_setup[1:0], gas_reading, alarm1_setpoint);
    wire alarm2_hit = alarm_hit(alarm_setup[3:2], gas_reading, alarm2_setpoint);
    wire low_now = (alarm1_hit && alarm_setup[1:0] == `ROLE_LOW) ||
                   (alarm2_hit && alarm_setup[3:2] == `ROLE_LOW) || ext_low_sync;
    wire high_now = (alarm1_hit && alarm_setup[1:0] == `ROLE_HIGH) ||
                    (alarm2_hit && alarm_setup[3:2] == `ROLE_HIGH) || ext_high_sync;
    always @(posedge clk) begin
        if (rst) begin
            status_error_flags <= 16'h0000;
            low_alarm <= 1'b0;
            high_alarm <= 1'b0;
        end else begin
            low_alarm <= low_now;
            high_alarm <= high_now;
            status_error_flags <= 16'h0000;
            status_error_flags[1] <= gas_out_of_range;
            status_error_flags[2] <= low_now;
            status_error_flags[3] <= high_now;
            status_error_flags[4] <= (comp_current_ua < `COMP_LOW_UA) || (comp_current_ua > `COMP_HIGH_UA);
            status_error_flags[5] <= (sensor_current_ua < sensor_low_ua) || (sensor_current_ua > sensor_high_ua);
            status_error_flags[6] <= not_stable || !in_band;
            status_error_flags[7] <= (cell_temp_dc < `CELL_MIN_DC) || (cell_temp_dc > `CELL_MAX_DC);
            status_error_flags[9] <= (vcomp_code <= `VCOMP_LOW) || (vcomp_code >= `VCOMP_HIGH);
            status_error_flags[10] <= board_temperature > cell_setpoint_c;
        end
    end

    // ----------------------------------------------------------------
    // Field outputs
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            field_cal_on <= 1'b0;
            ext_comp_on <= 1'b0;
            bg_comp_on <= 1'b0;
            display_limit_on <= 1'b0;
            brightness <= 8'h00;
            contrast <= 8'h00;
            temp_unit <= 2'h0;
            press_unit <= 2'h0;
            two_gas_cal <= 1'b0;
            date_us <= 1'b0;
            sensor_quantity <= 3'h0;
            alarm1_role <= 2'h0;
            alarm2_role <= 2'h0;
            namur_fault_ua <= `NAMUR_LOW_UA;
        end else begin
            field_cal_on <= settings_enables[`SET_FIELD_CAL];
            ext_comp_on <= settings_enables[`SET_EXT_COMP];
            bg_comp_on <= settings_enables[`SET_BG_COMP];
            display_limit_on <= settings_enables[`SET_DISP_LIMIT];
            brightness <= display_levels[15:8];
            contrast <= display_levels[7:0];
            temp_unit <= units_select[1:0];
            press_unit <= units_select[3:2];
            two_gas_cal <= units_select[`UNITS_CAL_TYPE];
            date_us <= units_select[`UNITS_DATE_US];
            sensor_quantity <= units_select[13:11];
            alarm1_role <= alarm_setup[1:0];
            alarm2_role <= alarm_setup[3:2];
            namur_fault_ua <= alarm_setup[`ALARM_NAMUR_HIGH] ? `NAMUR_HIGH_UA : `NAMUR_LOW_UA;
        end
    end

    // ----------------------------------------------------------------
    // Format converters
    // ----------------------------------------------------------------
    wire signed [16:0] raw_off = $signed({1'b0, conv_raw}) - $signed(`SCALED_OFFSET);
    always @(posedge clk) begin
        if (rst) begin
            conv_tenths <= 17'sd0;
            conv_hundredths <= 17'sd0;
            conv_signed <= 17'sd0;
            conv_in_range <= 1'b0;
        end else begin
            conv_tenths <= raw_off;
            conv_hundredths <= raw_off;
            conv_signed <= $signed({1'b0, conv_raw}) - $signed(`SIGNED_OFFSET);
            conv_in_range <= conv_raw <= `SCALED_MAX;
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    always @* begin
        next_err = 1'b0;
        case (reg_addr)
            `ADDR_SETTINGS: next_rdata = settings_enables;
            `ADDR_DISPLAY: next_rdata = display_levels;
            `ADDR_UNITS: next_rdata = units_select;
            `ADDR_ALARM_SETUP: next_rdata = alarm_setup;
            `ADDR_STATUS: next_rdata = status_error_flags;
            `ADDR_RTC_HOUR_MIN: next_rdata = {rtc_hour, rtc_min};
            `ADDR_RTC_SEC_DAY: next_rdata = {rtc_sec, rtc_day};
            `ADDR_RTC_MONTH_YEAR: next_rdata = {rtc_month, rtc_year};
            default: begin
                next_rdata = 16'h0000;
                next_err = 1'b1;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
            reg_err <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_err <= reg_rd & next_err;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end
endmodule // gas_register_formats
`default_nettype wire

//--- rtl/sync_bit.v
/*
 Two flip-flop synchroniser for one level.
 Assumes the input is asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module sync_bit (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Level
    input wire din,
    output reg dout
);
    reg meta;
    always @(posedge clk) begin
        if (rst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // sync_bit
`default_nettype wire

//--- tb/bus_master_model.sv
/*
 Serial bus master model: whole 16-bit register reads and writes.
 Assumes a rising-edge register port.
*/
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
    // Clock and answer
    input wire logic clk,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic reg_err,
    // Request
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic timed_out
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h55;
        reg_wdata = 16'hA5A5;
        timed_out = 1'b0;
    end
    // Released lines show the inverse
    task write_word(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task read_word(input logic [6:0] a, output logic [15:0] d, output logic e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk);
        if (reg_rvalid !== 1'b1) timed_out = 1'b1;
        d = reg_rdata;
        e = reg_err;
    endtask
endmodule // bus_master_model
`default_nettype wire

//--- tb/gas_register_formats_assertions.sv
/*
 Checks on the register port, field outputs and converters.
 Assumes binding into gas_register_formats.
*/
`timescale 1ns/10ps
`default_nettype none
module gas_register_formats_assertions (
    // Clock, reset and register port
    input wire logic clk, rst, reg_wr, reg_rd, reg_rvalid,
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    // Field outputs
    input wire logic field_cal_on, ext_comp_on, bg_comp_on, display_limit_on, two_gas_cal, date_us,
    input wire logic [1:0] temp_unit, press_unit, alarm1_role, alarm2_role,
    input wire logic [2:0] sensor_quantity,
    input wire logic [15:0] namur_fault_ua,
    // Converters
    input wire logic [15:0] conv_raw,
    input wire logic signed [16:0] conv_tenths, conv_hundredths, conv_signed,
    input wire logic conv_in_range
);
    // Write data at field output latency
    logic [15:0] wd1;
    logic [15:0] wd2;
    always @(posedge clk) begin
        wd1 <= reg_wdata;
        wd2 <= wd1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without a read");
    a_settings_fields: assert property (reg_wr && reg_addr == 7'h01 |=> ##1
        {display_limit_on, bg_comp_on, ext_comp_on, field_cal_on} == {wd2[5], wd2[3:2], wd2[0]})
        else $error("settings fields wrong");
    a_units_fields: assert property (reg_wr && reg_addr == 7'h03 |=> ##1
        {sensor_quantity, date_us, two_gas_cal, press_unit, temp_unit} == {wd2[13:11], wd2[5:0]})
        else $error("units fields wrong");
    a_alarm_roles: assert property (reg_wr && reg_addr == 7'h1B |=> ##1
        {alarm2_role, alarm1_role} == wd2[3:0])
        else $error("alarm roles wrong");
    a_namur_level: assert property (reg_wr && reg_addr == 7'h1B |=> ##1
        namur_fault_ua == (wd2[4] ? 16'h5398 : 16'h0C80))
        else $error("fault current level wrong");
    a_tenths_conv: assert property (!$past(rst) |->
        conv_tenths == $signed({1'b0, $past(conv_raw)}) - 17'sh04E20)
        else $error("one decimal conversion wrong");
    a_hundredths_conv: assert property (!$past(rst) |->
        conv_hundredths == $signed({1'b0, $past(conv_raw)}) - 17'sh04E20)
        else $error("two decimal conversion wrong");
    a_signed_conv: assert property (!$past(rst) |->
        conv_signed == $signed({1'b0, $past(conv_raw)}) - 17'sh07FFF)
        else $error("signed offset conversion wrong");
    a_range_flag: assert property (!$past(rst) |-> conv_in_range == ($past(conv_raw) <= 16'h9C40))
        else $error("range flag wrong");
    c_read: cover property (reg_rd ##1 reg_rvalid);
    c_alarm_write: cover property (reg_wr && reg_addr == 7'h1B);
    c_out_of_range: cover property (!conv_in_range ##1 conv_in_range);
endmodule // gas_register_formats_assertions
bind gas_register_formats gas_register_formats_assertions i_gas_register_formats_assertions (.*);
`default_nettype wire

//--- tb/tb_top.sv
/*
 Self-checking bench for the gas analyser register bank.
 Assumes a 10 MHz clock and the bus master model.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd, reg_rvalid, reg_err, timed_out, conv_in_range, er;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, namur_fault_ua, rd;
    logic [15:0] conv_raw = 16'h0000, gas_reading = 16'h4E20, alarm1_setpoint = 16'h2710;
    logic [15:0] alarm2_setpoint = 16'h7530, comp_current_ua = 16'h2EE0, sensor_current_ua = 16'h2EE0;
    logic [15:0] sensor_low_ua = 16'h0E10, sensor_high_ua = 16'h5208;
    logic signed [15:0] cell_temp_dc = 16'sh01F4, cell_temp_cc = 16'sh1388, cell_setpoint_cc = 16'sh1388;
    logic signed [15:0] board_temperature = 16'sh001E, cell_setpoint_c = 16'sh0032;
    logic [12:0] vcomp_code = 13'h0FA0;
    logic gas_out_of_range = 1'b0, second_tick = 1'b0, ext_low_alarm_pin = 1'b0, ext_high_alarm_pin = 1'b0;
    logic field_cal_on, ext_comp_on, bg_comp_on, display_limit_on, two_gas_cal, date_us, low_alarm, high_alarm;
    logic [7:0] brightness, contrast;
    logic [1:0] temp_unit, press_unit, alarm1_role, alarm2_role;
    logic [2:0] sensor_quantity;
    logic signed [16:0] conv_tenths, conv_hundredths, conv_signed;
    int fails = 0;
    int compares = 0;
    always #50 clk = ~clk;
    gas_register_formats #(.STABLE_HOLD(34'd20)) i_gas_register_formats (.*);
    bus_master_model i_bus_master_model (.*);
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task wr(input logic [6:0] a, input logic [15:0] d);
        i_bus_master_model.write_word(a, d);
    endtask
    task rd_chk(input logic [6:0] a, input logic [15:0] exp, input logic exp_err);
        i_bus_master_model.read_word(a, rd, er);
        if (timed_out) begin
            fails++;
            close_out;
        end
        check(rd, exp);
        check(er, exp_err);
    endtask
    task stat(input logic [15:0] exp);
        repeat (5) @(posedge clk);
        rd_chk(7'h4D, exp, 1'b0);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        rd_chk(7'h4D, 16'h0040, 1'b0);
        rd_chk(7'h01, 16'h0000, 1'b0);
        rd_chk(7'h02, 16'h3232, 1'b0);
        rd_chk(7'h03, 16'h0000, 1'b0);
        rd_chk(7'h1B, 16'h0000, 1'b0);
        rd_chk(7'h7F, 16'h0000, 1'b1);
        check({brightness, contrast}, 16'h3232);
        check(namur_fault_ua, 16'h0C80);
        $display("reset test done");
    endtask
    task t_masks;
        wr(7'h01, 16'hFFFF);
        wr(7'h03, 16'hFFFF);
        wr(7'h1B, 16'hFFFF);
        wr(7'h4D, 16'hFFFF);
        rd_chk(7'h01, 16'h002D, 1'b0);
        rd_chk(7'h03, 16'h383F, 1'b0);
        rd_chk(7'h1B, 16'h001F, 1'b0);
        wr(7'h01, 16'h0024);
        rd_chk(7'h01, 16'h0024, 1'b0);
        check({display_limit_on, bg_comp_on, ext_comp_on, field_cal_on}, 4'hA);
        $display("mask test done");
    endtask
    task t_units;
        logic [15:0] w;
        for (int k = 0; k < 5; k++) begin
            w = (k << 11) | (k[0] << 5) | (!k[0] << 4) | ((k % 3) << 2) | (k % 3);
            wr(7'h03, w);
            rd_chk(7'h03, w, 1'b0);
            check({temp_unit, press_unit}, {2'(k % 3), 2'(k % 3)});
            check({date_us, two_gas_cal}, {k[0], !k[0]});
            check(sensor_quantity, k[2:0]);
        end
        $display("units test done");
    endtask
    task t_alarm;
        for (int k = 0; k < 3; k++) begin
            wr(7'h1B, (k[0] << 4) | ((2 - k) << 2) | k);
            rd_chk(7'h1B, (k[0] << 4) | ((2 - k) << 2) | k, 1'b0);
            check({alarm2_role, alarm1_role}, {2'(2 - k), k[1:0]});
            check(namur_fault_ua, k[0] ? 16'h5398 : 16'h0C80);
        end
        $display("alarm test done");
    endtask
    task t_display;
        wr(7'h02, 16'h6F37);
        rd_chk(7'h02, 16'h6432, 1'b0);
        wr(7'h02, 16'h5A63);
        rd_chk(7'h02, 16'h5A5A, 1'b0);
        check({brightness, contrast}, 16'h5A5A);
        $display("display test done");
    endtask
    task t_status;
        wr(7'h1B, 16'h0009);
        stat(16'h0000);
        @(posedge clk) gas_out_of_range <= 1'b1;
        stat(16'h0002);
        @(posedge clk) gas_out_of_range <= 1'b0;
        alarm1_setpoint <= 16'h4E21;
        stat(16'h0004);
        check(low_alarm, 1'b1);
        @(posedge clk) alarm1_setpoint <= 16'h2710;
        gas_reading <= 16'h7531;
        stat(16'h0008);
        check(high_alarm, 1'b1);
        @(posedge clk) gas_reading <= 16'h4E20;
        ext_low_alarm_pin <= 1'b1;
        stat(16'h0004);
        @(posedge clk) ext_low_alarm_pin <= 1'b0;
        ext_high_alarm_pin <= 1'b1;
        stat(16'h0008);
        @(posedge clk) ext_high_alarm_pin <= 1'b0;
        comp_current_ua <= 16'h0E0F;
        stat(16'h0010);
        @(posedge clk) comp_current_ua <= 16'h0E10;
        stat(16'h0000);
        @(posedge clk) comp_current_ua <= 16'h5209;
        stat(16'h0010);
        @(posedge clk) comp_current_ua <= 16'h5208;
        sensor_current_ua <= 16'h0E0F;
        stat(16'h0020);
        @(posedge clk) sensor_current_ua <= 16'h2EE0;
        sensor_high_ua <= 16'h2EDF;
        stat(16'h0020);
        @(posedge clk) sensor_high_ua <= 16'h5208;
        cell_temp_dc <= 16'shFE0B;
        stat(16'h0080);
        @(posedge clk) cell_temp_dc <= 16'sh0321;
        stat(16'h0080);
        @(posedge clk) cell_temp_dc <= 16'shFE0C;
        vcomp_code <= 13'h0001;
        stat(16'h0200);
        @(posedge clk) vcomp_code <= 13'h1FFF;
        stat(16'h0200);
        @(posedge clk) vcomp_code <= 13'h0002;
        board_temperature <= 16'sh0033;
        stat(16'h0400);
        @(posedge clk) board_temperature <= 16'sh0032;
        stat(16'h0000);
        @(posedge clk) cell_setpoint_c <= 16'sh0031;
        stat(16'h0400);
        @(posedge clk) cell_setpoint_c <= 16'sh0032;
        cell_temp_cc <= 16'sh1398;
        stat(16'h0040);
        @(posedge clk) cell_temp_cc <= 16'sh1388;
        rd_chk(7'h4D, 16'h0040, 1'b0);
        repeat (25) @(posedge clk);
        rd_chk(7'h4D, 16'h0000, 1'b0);
        $display("status test done");
    endtask
    task t_clock;
        wr(7'h41, 16'hAB17);
        wr(7'h42, 16'hCD05);
        wr(7'h43, 16'hFF0C);
        wr(7'h44, 16'h0103);
        wr(7'h45, 16'h8018);
        repeat (2) begin
            @(posedge clk) second_tick <= 1'b1;
            @(posedge clk) second_tick <= 1'b0;
        end
        rd_chk(7'h4E, 16'h1705, 1'b0);
        rd_chk(7'h4F, 16'h020C, 1'b0);
        rd_chk(7'h50, 16'h0318, 1'b0);
        $display("clock test done");
    endtask
    task t_conv;
        logic [15:0] raws [5];
        raws = '{16'h0000, 16'h4E20, 16'h9C40, 16'h9C41, 16'hFFFF};
        foreach (raws[i]) begin
            @(posedge clk) conv_raw <= raws[i];
            repeat (2) @(posedge clk);
            check(conv_tenths, $signed({1'b0, raws[i]}) - 17'sh04E20);
            check(conv_hundredths, $signed({1'b0, raws[i]}) - 17'sh04E20);
            check(conv_signed, $signed({1'b0, raws[i]}) - 17'sh07FFF);
            check(conv_in_range, raws[i] <= 16'h9C40);
        end
        $display("converter test done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_masks;
        t_units;
        t_alarm;
        t_display;
        t_status;
        t_clock;
        t_conv;
        close_out;
    end
endmodule // tb_top
`default_nettype wire
